// File: verilog/pia_allocator.sv
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
// Contract
// - Analog value is two-byte signed word
// - Zero is zero; 7FFF/8000 are full scale
// - Unresolved low bits ignored out, zero in
// - Optional control/status byte at lowest byte
// - Special channels like analog, any width; code moves at most DAT_BYTES data bytes per channel
// - Analog and special slots word aligned
// - Default placement starts at address zero
// - Terminals may bypass to fieldbus image
// - Scan terminals left to right at start
// - Order: aout, dout, ain, din; bytes first
// - Programmed mode maps single bits freely
// - Auto mode maps one offset/length window
// - Word and status byte move together
// - Byte bits sampled and updated together
// - One bit per digital channel, split blocks
module pia_allocator #(
	parameter int MAX_TERM = 16,
	parameter int IMG_BYTES = 32,
	parameter int FB_BYTES = 8,
	parameter int DAT_BYTES = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic scanReq,
	output logic [$clog2(MAX_TERM)-1:0] scanIdx,
	input wire logic scanAck,
	input wire logic scanPresent,
	input wire logic scanIsOut,
	input wire logic scanIsAna,
	input wire logic [pia_pkg::CHW-1:0] scanChans,
	input wire logic [pia_pkg::CHW-1:0] scanBytes,
	input wire logic [pia_pkg::CHW-1:0] scanRes,
	output logic xchgEn,
	input wire logic chInValid,
	input wire logic [$clog2(MAX_TERM)-1:0] chInTerm,
	input wire logic [pia_pkg::CHW-1:0] chInChan,
	input wire logic [7:0] chInStat,
	input wire logic [8*DAT_BYTES-1:0] chInData,
	input wire logic chOutReq,
	input wire logic [$clog2(MAX_TERM)-1:0] chOutTerm,
	input wire logic [pia_pkg::CHW-1:0] chOutChan,
	output logic chOutValid,
	output logic [7:0] chOutStat,
	output logic [8*DAT_BYTES-1:0] chOutData,
	input wire logic fbStrobe,
	input wire logic [8*FB_BYTES-1:0] fbRxImg,
	output logic [8*FB_BYTES-1:0] fbTxImg,
	output logic [8*IMG_BYTES-1:0] ctlInImg,
	input wire logic [8*IMG_BYTES-1:0] ctlOutImg,
	output logic [8*IMG_BYTES-1:0] fbDirInImg,
	input wire logic [8*IMG_BYTES-1:0] fbDirOutImg
);
	localparam int TW = $clog2(MAX_TERM);
	localparam int IB = 8 * IMG_BYTES; // Bits per image
	localparam int FBB = 8 * FB_BYTES; // Bits per fieldbus window
	localparam int AW = $clog2(IB);
	localparam int FW = $clog2(FBB);
	localparam int DW = 8 * DAT_BYTES;
	localparam int SW = DW + 8; // Slot: data plus status byte
	localparam logic [15:0] IB16 = 16'(IB);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rstSync_q; // Two-stage release
	logic rstN; // Synchronised reset for all logic
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstN = rstSync_q[1];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	pia_pkg::pia_state_t st_q, st_d;
	pia_pkg::pia_group_t grp_q, grp_d;
	logic [TW-1:0] idx_q, idx_d; // Scan and allocation pointer
	logic [TW:0] cnt_q, cnt_d; // Terminals found
	logic [15:0] curC_q, curC_d; // Next free bit, control image
	logic [15:0] curF_q, curF_d; // Next free bit, fieldbus direct image
	logic [15:0] outEnd_q, outEnd_d, inEnd_q, inEnd_d;
	logic ovf_q, ovf_d; // A slot ran past the image
	logic [2:0] ctrl_q, ctrl_d;
	logic [31:0] rxWin_q, rxWin_d, txWin_q, txWin_d;
	logic [MAX_TERM-1:0] byp_q, byp_d;
	logic [pia_pkg::MAPSEL_RX:0] mapSel_q, mapSel_d;
	// Terminal table, filled by the scan; bases set by the allocation
	logic tOut_q [MAX_TERM];
	logic tAna_q [MAX_TERM];
	logic [3:0] tCh_q [MAX_TERM];
	logic [3:0] tBy_q [MAX_TERM];
	logic [3:0] tRes_q [MAX_TERM];
	logic [15:0] tBase_q [MAX_TERM];
	logic [15:0] mapTx_q [FBB]; // Control output bit per fieldbus bit
	logic [15:0] mapRx_q [FBB]; // Control input bit per fieldbus bit
	logic scanWr, allocWr, mapWr, hit, csb, run;
	logic [15:0] cur, newBase, newCur, mapVal;

	assign csb = ctrl_q[pia_pkg::CTRL_CSB];
	assign run = (st_q == pia_pkg::ST_RUN);
	assign xchgEn = run;
	assign scanReq = (st_q == pia_pkg::ST_SCAN);
	assign scanIdx = idx_q;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Slot bytes rounded up to a whole word
	function automatic logic [4:0] slotB(input logic [3:0] nb, input logic cs);
		logic [4:0] s;
		s = 5'(nb) + 5'(cs);
		slotB = s + 5'(s[0]);
	endfunction

	// Clears bits below the channel's resolution
	function automatic logic [DW-1:0] resMask(input logic [3:0] r, input logic [3:0] nb);
		resMask = '1;
		if (nb == pia_pkg::ANA_BYTES && r != 4'h0 && r < pia_pkg::ANA_RES) begin
			resMask[15:0] = 16'hFFFF << (pia_pkg::ANA_RES - r);
		end
	endfunction

	// Bit address of a channel inside its terminal's slot
	function automatic logic [15:0] chPos(input logic [TW-1:0] t, input logic [3:0] c);
		if (tAna_q[t]) begin
			chPos = tBase_q[t] + ((16'(c) * 16'(slotB(tBy_q[t], csb))) << pia_pkg::BYTE_SH);
		end else begin
			chPos = tBase_q[t] + 16'(c);
		end
	endfunction

	// Writes a whole slot in one step
	function automatic logic [IB-1:0] putSlot(input logic [IB-1:0] img, input logic [15:0] p,
		input logic [4:0] n, input logic [SW-1:0] s);
		logic [15:0] k;
		putSlot = img;
		for (int b = 0; b < IMG_BYTES; b++) begin
			k = 16'(b) - (p >> pia_pkg::BYTE_SH);
			if (16'(b) >= (p >> pia_pkg::BYTE_SH) && k < 16'(n) && k < 16'(DAT_BYTES + 1)) begin
				putSlot[b*8+:8] = s[k*8+:8];
			end
		end
	endfunction

	// Reads a whole slot in one step
	function automatic logic [SW-1:0] getSlot(input logic [IB-1:0] img, input logic [15:0] p);
		logic [15:0] b;
		getSlot = '0;
		for (int k = 0; k <= DAT_BYTES; k++) begin
			b = (p >> pia_pkg::BYTE_SH) + 16'(k);
			if (b < 16'(IMG_BYTES)) getSlot[k*8+:8] = img[b*8+:8];
		end
	endfunction

	// ------------------------------------------------------------
	// Scan and allocation
	// ------------------------------------------------------------
	assign cur = byp_q[idx_q] ? curF_q : curC_q;
	assign hit = ({1'b0, idx_q} < cnt_q) && (tOut_q[idx_q] == !grp_q[1])
		&& (tAna_q[idx_q] == !grp_q[0]);

	// Next state of the scan/allocation sequencer
	always_comb begin
		st_d = st_q;
		grp_d = grp_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		curC_d = curC_q;
		curF_d = curF_q;
		outEnd_d = outEnd_q;
		inEnd_d = inEnd_q;
		ovf_d = ovf_q;
		scanWr = 1'b0;
		allocWr = 1'b0;
		newBase = cur;
		newCur = cur;
		case (st_q)
		pia_pkg::ST_SCAN: begin
			// Left to right until a gap or the table is full
			if (scanAck) begin
				scanWr = scanPresent;
				if (scanPresent) cnt_d = cnt_q + 1'b1;
				if (!scanPresent || idx_q == TW'(MAX_TERM - 1)) st_d = pia_pkg::ST_WAIT;
				else idx_d = idx_q + 1'b1;
			end
		end
		pia_pkg::ST_WAIT: begin
			// Hold until software has set the placement options
			if (ctrl_q[pia_pkg::CTRL_GO]) begin
				st_d = pia_pkg::ST_ALLOC;
				grp_d = pia_pkg::G_AOUT;
				idx_d = '0;
				curC_d = 16'h0;
				curF_d = 16'h0;
			end
		end
		pia_pkg::ST_ALLOC: begin
			if (hit) begin
				allocWr = 1'b1;
				if (tAna_q[idx_q]) begin
					newBase = (cur + pia_pkg::WORD_MASK) & ~pia_pkg::WORD_MASK;
					newCur = newBase + ((16'(tCh_q[idx_q]) * 16'(slotB(tBy_q[idx_q], csb)))
						<< pia_pkg::BYTE_SH);
				end else begin
					newCur = cur + 16'(tCh_q[idx_q]);
				end
				if (byp_q[idx_q]) curF_d = newCur;
				else curC_d = newCur;
				if (newCur > IB16) ovf_d = 1'b1;
			end
			if (idx_q == TW'(MAX_TERM - 1)) begin
				idx_d = '0;
				grp_d = pia_pkg::pia_group_t'(grp_q + 2'h1);
				if (grp_q == pia_pkg::G_DOUT) begin
					// Inputs get their own space from zero
					outEnd_d = curC_d;
					curC_d = 16'h0;
					curF_d = 16'h0;
				end
				if (grp_q == pia_pkg::G_DIN) begin
					inEnd_d = curC_d;
					st_d = pia_pkg::ST_RUN;
				end
			end else begin
				idx_d = idx_q + 1'b1;
			end
		end
		pia_pkg::ST_RUN: st_d = st_q; // Fixed until reset
		default: st_d = pia_pkg::ST_SCAN;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			st_q <= pia_pkg::ST_SCAN;
			grp_q <= pia_pkg::G_AOUT;
			idx_q <= '0;
			cnt_q <= '0;
			curC_q <= 16'h0;
			curF_q <= 16'h0;
			outEnd_q <= 16'h0;
			inEnd_q <= 16'h0;
			ovf_q <= 1'b0;
		end else begin
			st_q <= st_d;
			grp_q <= grp_d;
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			curC_q <= curC_d;
			curF_q <= curF_d;
			outEnd_q <= outEnd_d;
			inEnd_q <= inEnd_d;
			ovf_q <= ovf_d;
		end
	end

	// Terminal table and programmed map
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < MAX_TERM; i++) begin
				tOut_q[i] <= 1'b0;
				tAna_q[i] <= 1'b0;
				tCh_q[i] <= 4'h0;
				tBy_q[i] <= 4'h0;
				tRes_q[i] <= 4'h0;
				tBase_q[i] <= 16'h0;
			end
			for (int k = 0; k < FBB; k++) begin
				mapTx_q[k] <= 16'h0;
				mapRx_q[k] <= 16'h0;
			end
		end else begin
			if (scanWr) begin
				tOut_q[idx_q] <= scanIsOut;
				tAna_q[idx_q] <= scanIsAna;
				tCh_q[idx_q] <= scanChans;
				tBy_q[idx_q] <= scanBytes;
				tRes_q[idx_q] <= scanRes;
			end
			if (allocWr) tBase_q[idx_q] <= newBase;
			if (mapWr && mapSel_q[pia_pkg::MAPSEL_RX]) mapRx_q[mapSel_q[FW-1:0]] <= mapVal;
			if (mapWr && !mapSel_q[pia_pkg::MAPSEL_RX]) mapTx_q[mapSel_q[FW-1:0]] <= mapVal;
		end
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic awHave_q, awHave_d, wHave_q, wHave_d, bV_q, bV_d, rV_q, rV_d;
	logic [5:0] awA_q, awA_d;
	logic [31:0] wD_q, wD_d, rD_q, rD_d, wMask, wVal;
	logic [3:0] wS_q, wS_d;
	logic [1:0] bR_q, bR_d, rR_q, rR_d;

	// Address decode shared by reads and writes
	function automatic logic regOk(input logic [5:0] a);
		regOk = (a[1:0] == 2'h0) && (a <= pia_pkg::REG_MAPDAT);
	endfunction

	// Current register contents
	function automatic logic [31:0] rdReg(input logic [5:0] a);
		rdReg = 32'h0;
		case (a)
		pia_pkg::REG_CTRL: rdReg[2:0] = ctrl_q;
		pia_pkg::REG_STAT: begin
			rdReg[pia_pkg::STAT_DONE] = run;
			rdReg[pia_pkg::STAT_OVF] = ovf_q;
			rdReg[pia_pkg::STAT_CNT+:8] = 8'(cnt_q);
		end
		pia_pkg::REG_ENDS: rdReg = {inEnd_q, outEnd_q};
		pia_pkg::REG_RXWIN: rdReg = rxWin_q;
		pia_pkg::REG_TXWIN: rdReg = txWin_q;
		pia_pkg::REG_BYPASS: rdReg[MAX_TERM-1:0] = byp_q;
		pia_pkg::REG_MAPSEL: rdReg[pia_pkg::MAPSEL_RX:0] = mapSel_q;
		pia_pkg::REG_MAPDAT: rdReg[15:0] = mapSel_q[pia_pkg::MAPSEL_RX] ?
			mapRx_q[mapSel_q[FW-1:0]] : mapTx_q[mapSel_q[FW-1:0]];
		default: rdReg = 32'h0;
		endcase
	endfunction

	assign s_axi_awready = !awHave_q;
	assign s_axi_wready = !wHave_q;
	assign s_axi_bvalid = bV_q;
	assign s_axi_bresp = bR_q;
	assign s_axi_arready = !rV_q;
	assign s_axi_rvalid = rV_q;
	assign s_axi_rdata = rD_q;
	assign s_axi_rresp = rR_q;

	// Bus handshakes and register writes
	always_comb begin
		awHave_d = awHave_q;
		awA_d = awA_q;
		wHave_d = wHave_q;
		wD_d = wD_q;
		wS_d = wS_q;
		bV_d = bV_q && !s_axi_bready;
		bR_d = bR_q;
		rV_d = rV_q && !s_axi_rready;
		rD_d = rD_q;
		rR_d = rR_q;
		ctrl_d = ctrl_q;
		rxWin_d = rxWin_q;
		txWin_d = txWin_q;
		byp_d = byp_q;
		mapSel_d = mapSel_q;
		mapWr = 1'b0;
		for (int i = 0; i < 4; i++) wMask[i*8+:8] = {8{wS_q[i]}};
		wVal = (rdReg(awA_q) & ~wMask) | (wD_q & wMask);
		mapVal = wVal[15:0];
		if (s_axi_awvalid && !awHave_q) begin
			awHave_d = 1'b1;
			awA_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHave_q) begin
			wHave_d = 1'b1;
			wD_d = s_axi_wdata;
			wS_d = s_axi_wstrb;
		end
		// Commit once both halves are in and the last answer is gone
		if (awHave_q && wHave_q && !bV_q) begin
			awHave_d = 1'b0;
			wHave_d = 1'b0;
			bV_d = 1'b1;
			bR_d = regOk(awA_q) ? pia_pkg::RESP_OKAY : pia_pkg::RESP_SLVERR;
			case (awA_q)
			pia_pkg::REG_CTRL: begin
				ctrl_d[pia_pkg::CTRL_AUTO] = wVal[pia_pkg::CTRL_AUTO];
				// Placement options freeze once allocation starts
				if (!ctrl_q[pia_pkg::CTRL_GO]) ctrl_d[pia_pkg::CTRL_CSB] = wVal[pia_pkg::CTRL_CSB];
				ctrl_d[pia_pkg::CTRL_GO] = ctrl_q[pia_pkg::CTRL_GO] | wVal[pia_pkg::CTRL_GO];
			end
			pia_pkg::REG_RXWIN: rxWin_d = wVal;
			pia_pkg::REG_TXWIN: txWin_d = wVal;
			pia_pkg::REG_BYPASS: if (!ctrl_q[pia_pkg::CTRL_GO]) byp_d = wVal[MAX_TERM-1:0];
			pia_pkg::REG_MAPSEL: mapSel_d = wVal[pia_pkg::MAPSEL_RX:0];
			pia_pkg::REG_MAPDAT: mapWr = 1'b1;
			default: mapWr = 1'b0;
			endcase
		end
		if (s_axi_arvalid && !rV_q) begin
			rV_d = 1'b1;
			rD_d = rdReg(s_axi_araddr);
			rR_d = regOk(s_axi_araddr) ? pia_pkg::RESP_OKAY : pia_pkg::RESP_SLVERR;
		end
	end

	// Bus and configuration registers
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			{awHave_q, wHave_q, bV_q, rV_q} <= 4'h0;
			awA_q <= 6'h00;
			wD_q <= 32'h0;
			wS_q <= 4'h0;
			bR_q <= pia_pkg::RESP_OKAY;
			rD_q <= 32'h0;
			rR_q <= pia_pkg::RESP_OKAY;
			ctrl_q <= pia_pkg::CTRL_RST;
			rxWin_q <= 32'h0;
			txWin_q <= 32'h0;
			byp_q <= '0; // All terminals in the control image
			mapSel_q <= '0;
		end else begin
			{awHave_q, wHave_q, bV_q, rV_q} <= {awHave_d, wHave_d, bV_d, rV_d};
			awA_q <= awA_d;
			wD_q <= wD_d;
			wS_q <= wS_d;
			bR_q <= bR_d;
			rD_q <= rD_d;
			rR_q <= rR_d;
			ctrl_q <= ctrl_d;
			rxWin_q <= rxWin_d;
			txWin_q <= txWin_d;
			byp_q <= byp_d;
			mapSel_q <= mapSel_d;
		end
	end

	// ------------------------------------------------------------
	// Process data exchange
	// ------------------------------------------------------------
	logic [IB-1:0] ctlIn_q, ctlIn_d, fbDir_q, fbDir_d;
	logic [FBB-1:0] fbTx_q, fbTx_d;
	logic chOutV_q, chOutV_d, inOk, outOk;
	logic [7:0] chOutS_q, chOutS_d;
	logic [DW-1:0] chOutD_q, chOutD_d, inData;
	logic [15:0] inPos, outPos;
	logic [SW-1:0] inSlot, outSlot;

	assign inOk = run && chInValid && ({1'b0, chInTerm} < cnt_q) && !tOut_q[chInTerm]
		&& (chInChan < tCh_q[chInTerm]);
	assign outOk = run && chOutReq && ({1'b0, chOutTerm} < cnt_q) && tOut_q[chOutTerm]
		&& (chOutChan < tCh_q[chOutTerm]);
	assign inPos = chPos(chInTerm, chInChan);
	assign outPos = chPos(chOutTerm, chOutChan);
	// Signed words pass with bits below the resolution cleared; 8000 stays full scale
	assign inData = chInData & resMask(tRes_q[chInTerm], tBy_q[chInTerm]);
	assign inSlot = csb ? {inData, chInStat} : {8'h00, inData};
	assign outSlot = getSlot(byp_q[chOutTerm] ? fbDirOutImg : ctlOutImg, outPos);

	// Image updates, one channel and one window per cycle
	always_comb begin
		logic [15:0] p;
		p = 16'h0;
		ctlIn_d = ctlIn_q;
		fbDir_d = fbDir_q;
		fbTx_d = fbTx_q;
		chOutV_d = outOk;
		chOutS_d = chOutS_q;
		chOutD_d = chOutD_q;
		// Fieldbus window taken and given as a whole image
		if (run && fbStrobe) begin
			for (int k = 0; k < FBB; k++) begin
				if (ctrl_q[pia_pkg::CTRL_AUTO]) begin
					p = 16'(k) + (txWin_q[15:0] << pia_pkg::BYTE_SH);
					fbTx_d[k] = (16'(k) < (txWin_q[31:16] << pia_pkg::BYTE_SH)) && (p < IB16)
						&& ctlOutImg[p[AW-1:0]];
				end else begin
					fbTx_d[k] = (mapTx_q[k] < IB16) && ctlOutImg[mapTx_q[k][AW-1:0]];
					if (mapRx_q[k] < IB16) ctlIn_d[mapRx_q[k][AW-1:0]] = fbRxImg[k];
				end
			end
			if (ctrl_q[pia_pkg::CTRL_AUTO]) begin
				for (int i = 0; i < IB; i++) begin
					p = 16'(i) - (rxWin_q[15:0] << pia_pkg::BYTE_SH);
					if (16'(i) >= (rxWin_q[15:0] << pia_pkg::BYTE_SH)
						&& p < (rxWin_q[31:16] << pia_pkg::BYTE_SH) && p < 16'(FBB)) begin
						ctlIn_d[i] = fbRxImg[p[FW-1:0]];
					end
				end
			end
		end
		// Terminal input lands in its own image, whole slot at once
		if (inOk) begin
			if (tAna_q[chInTerm]) begin
				if (byp_q[chInTerm]) begin
					fbDir_d = putSlot(fbDir_q, inPos, slotB(tBy_q[chInTerm], csb), inSlot);
				end else begin
					ctlIn_d = putSlot(ctlIn_d, inPos, slotB(tBy_q[chInTerm], csb), inSlot);
				end
			end else if (inPos < IB16) begin
				if (byp_q[chInTerm]) fbDir_d[inPos[AW-1:0]] = chInData[0];
				else ctlIn_d[inPos[AW-1:0]] = chInData[0];
			end
		end
		// Terminal output read with a one-cycle answer
		if (outOk) begin
			if (tAna_q[chOutTerm]) begin
				chOutD_d = (csb ? outSlot[SW-1:8] : outSlot[DW-1:0])
					& resMask(tRes_q[chOutTerm], tBy_q[chOutTerm]);
				chOutS_d = csb ? outSlot[7:0] : 8'h00;
			end else begin
				chOutD_d = '0;
				chOutD_d[0] = (outPos < IB16) && (byp_q[chOutTerm] ?
					fbDirOutImg[outPos[AW-1:0]] : ctlOutImg[outPos[AW-1:0]]);
				chOutS_d = 8'h00;
			end
		end
	end

	// Image registers
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ctlIn_q <= '0;
			fbDir_q <= '0;
			fbTx_q <= '0;
			chOutV_q <= 1'b0;
			chOutS_q <= 8'h00;
			chOutD_q <= '0;
		end else begin
			ctlIn_q <= ctlIn_d;
			fbDir_q <= fbDir_d;
			fbTx_q <= fbTx_d;
			chOutV_q <= chOutV_d;
			chOutS_q <= chOutS_d;
			chOutD_q <= chOutD_d;
		end
	end

	assign ctlInImg = ctlIn_q;
	assign fbDirInImg = fbDir_q;
	assign fbTxImg = fbTx_q;
	assign chOutValid = chOutV_q;
	assign chOutStat = chOutS_q;
	assign chOutData = chOutD_q;
endmodule

// File: verilog/pia_pkg.sv
package pia_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [5:0] REG_CTRL = 6'h00; // Mode and start
	localparam logic [5:0] REG_STAT = 6'h04; // Scan and alloc state
	localparam logic [5:0] REG_ENDS = 6'h08; // First free bit, out/in
	localparam logic [5:0] REG_RXWIN = 6'h0C; // Fieldbus to control inputs
	localparam logic [5:0] REG_TXWIN = 6'h10; // Control outputs to fieldbus
	localparam logic [5:0] REG_BYPASS = 6'h14; // Per-terminal fieldbus direct
	localparam logic [5:0] REG_MAPSEL = 6'h18; // Programmed map pointer
	localparam logic [5:0] REG_MAPDAT = 6'h1C; // Programmed map entry

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_CSB = 1;
	localparam int CTRL_GO = 2;
	localparam logic [2:0] CTRL_RST = 3'h1; // Automatic mapping, no status byte
	localparam int STAT_DONE = 0;
	localparam int STAT_OVF = 1;
	localparam int STAT_CNT = 8;
	localparam int MAPSEL_RX = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Analog format
	// ------------------------------------------------------------
	localparam int CHW = 4; // Width of channel count, byte count, resolution
	localparam logic [3:0] ANA_BYTES = 4'h2; // Plain analog value
	localparam logic [3:0] ANA_RES = 4'hF; // Full magnitude resolution
	localparam logic [15:0] WORD_MASK = 16'h000F; // Bit address of a word
	localparam int BYTE_SH = 3;

	typedef enum logic [1:0] {
		ST_SCAN = 2'h0,
		ST_WAIT = 2'h1,
		ST_ALLOC = 2'h3,
		ST_RUN = 2'h2
	} pia_state_t;

	typedef enum logic [1:0] {
		G_AOUT = 2'h0,
		G_DOUT = 2'h1,
		G_AIN = 2'h2,
		G_DIN = 2'h3
	} pia_group_t;
endpackage

// File: verif/pia_allocator_props.sv
`timescale 1ns/100ps
module pia_allocator_props #(
	parameter int MAX_TERM = 16,
	parameter int IMG_BYTES = 32,
	parameter int FB_BYTES = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic scanReq,
	input wire logic [$clog2(MAX_TERM)-1:0] scanIdx,
	input wire logic scanAck,
	input wire logic scanPresent,
	input wire logic xchgEn,
	input wire logic chInValid,
	input wire logic chOutReq,
	input wire logic chOutValid,
	input wire logic fbStrobe,
	input wire logic [8*FB_BYTES-1:0] fbTxImg,
	input wire logic [8*IMG_BYTES-1:0] ctlInImg,
	input wire logic [8*IMG_BYTES-1:0] fbDirInImg
);
	// ----
	// One domain, so one default
	// ----
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_step;
		scanReq && scanAck && scanPresent && scanIdx != '1;
	endsequence
	sequence s_last;
		scanReq && scanAck && !scanPresent;
	endsequence
	property p_scan_step;
		s_step |=> scanIdx == $past(scanIdx) + 1'b1;
	endproperty
	a_scan_step: assert property (p_scan_step) else $error("scan index stuck");
	property p_scan_end;
		s_last |=> !scanReq [*4];
	endproperty
	a_scan_end: assert property (p_scan_end) else $error("scan did not stop");
	property p_no_early;
		scanReq |-> !xchgEn;
	endproperty
	a_no_early: assert property (p_no_early) else $error("exchange during scan");
	property p_xchg_hold;
		xchgEn |=> xchgEn;
	endproperty
	a_xchg_hold: assert property (p_xchg_hold) else $error("exchange dropped");
	property p_out_after;
		chOutValid |-> $past(chOutReq) && xchgEn;
	endproperty
	a_out_after: assert property (p_out_after) else $error("unrequested output");
	property p_in_held;
		!xchgEn |=> $stable(ctlInImg);
	endproperty
	a_in_held: assert property (p_in_held) else $error("input image moved early");
	property p_dir_held;
		!chInValid |=> $stable(fbDirInImg);
	endproperty
	a_dir_held: assert property (p_dir_held) else $error("direct image moved");
	property p_tx_held;
		!fbStrobe |=> $stable(fbTxImg);
	endproperty
	a_tx_held: assert property (p_tx_held) else $error("tx image moved");
endmodule

// File: verif/pia_terminals.sv
`timescale 1ns/100ps
module pia_terminals (
	input wire logic clk_sys,
	input wire logic en,
	input wire logic scanReq,
	input wire logic [3:0] scanIdx,
	output logic scanAck,
	output logic scanPresent,
	output logic scanIsOut,
	output logic scanIsAna,
	output logic [3:0] scanChans,
	output logic [3:0] scanBytes,
	output logic [3:0] scanRes
);
	logic [1:0] waitQ = 2'h0; // Delay before next answer
	logic [14:0] desc; // Packed descriptor
	assign {scanPresent, scanIsOut, scanIsAna, scanChans, scanBytes, scanRes} = desc;
	// Chain nearest first: aout x2, din x4, dout x2, ain res 12
	always_comb begin
		case (scanIdx)
			4'h0: desc = 15'h722F;
			4'h1: desc = 15'h4400;
			4'h2: desc = 15'h6200;
			4'h3: desc = 15'h512C;
			default: desc = 15'h0;
		endcase
	end
	// Odd slots answer late so slow replies are exercised too
	always @(posedge clk_sys) begin
		scanAck <= 1'h0;
		if (en && scanReq && !scanAck && waitQ != 2'h0)
			waitQ <= waitQ - 2'h1;
		else if (en && scanReq && !scanAck) begin
			scanAck <= 1'h1;
			waitQ <= scanIdx[0] ? 2'h0 : 2'h3;
		end
	end
endmodule

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic clk_sys = 1'h0, rst_n = 1'h0, en = 1'h0;
	logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, chInData = 32'h0, chOutData, d;
	logic [3:0] s_axi_wstrb = 4'hF, scanIdx, scanChans, scanBytes, scanRes;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic scanReq, scanAck, scanPresent, scanIsOut, scanIsAna, xchgEn, chOutValid;
	logic chInValid = 1'h0, chOutReq = 1'h0, fbStrobe = 1'h0;
	logic [3:0] chInTerm = 4'h0, chInChan = 4'h0, chOutTerm = 4'h0, chOutChan = 4'h0;
	logic [7:0] chInStat = 8'h0, chOutStat;
	logic [63:0] fbRxImg = 64'hC3, fbTxImg;
	// Analog out 8000/1234, digital out bit 33, window byte 5
	logic [255:0] ctlOutImg = 256'hA502_1234_8000, fbDirOutImg = 256'h0, ctlInImg, fbDirInImg;
	int mismatches = 0, samples_checked = 0;
	always #4 clk_sys = ~clk_sys;
	pia_allocator dut_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scanReq, .scanIdx, .scanAck,
		.scanPresent, .scanIsOut, .scanIsAna, .scanChans, .scanBytes, .scanRes, .xchgEn,
		.chInValid, .chInTerm, .chInChan, .chInStat, .chInData, .chOutReq, .chOutTerm,
		.chOutChan, .chOutValid, .chOutStat, .chOutData, .fbStrobe, .fbRxImg, .fbTxImg,
		.ctlInImg, .ctlOutImg, .fbDirInImg, .fbDirOutImg);
	pia_terminals term_u (.clk_sys, .en, .scanReq, .scanIdx, .scanAck, .scanPresent,
		.scanIsOut, .scanIsAna, .scanChans, .scanBytes, .scanRes);
	// ----
	// Shared tasks
	// ----
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Each valid drops at the edge that takes it
	task automatic axw(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, pia_pkg::RESP_OKAY});
	endtask
	task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic putIn(input logic [3:0] t, input logic [3:0] c, input logic [31:0] d);
		@(posedge clk_sys);
		{chInValid, chInTerm, chInChan, chInData} <= {1'h1, t, c, d};
		@(posedge clk_sys);
		chInValid <= 1'h0;
		@(negedge clk_sys);
	endtask
	task automatic getOut(input logic [3:0] t, c, input logic [31:0] m, e);
		@(posedge clk_sys);
		chOutReq <= 1'h1;
		chOutTerm <= t;
		chOutChan <= c;
		@(posedge clk_sys);
		chOutReq <= 1'h0;
		@(negedge clk_sys);
		chk("chOutValid", {31'h0, chOutValid}, 32'h1);
		chk("chOutData", chOutData & m, e);
		chk("chOutStat", {24'h0, chOutStat}, 32'h0);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic tRegs();
		axr(pia_pkg::REG_CTRL, d, r);
		chk("ctrl", d, {29'h0, pia_pkg::CTRL_RST});
		axr(6'h20, d, r);
		chk("unmapped", {30'h0, r}, {30'h0, pia_pkg::RESP_SLVERR});
		axw(pia_pkg::REG_BYPASS, 32'h2);
		axw(pia_pkg::REG_TXWIN, 32'h0001_0005);
		axw(pia_pkg::REG_RXWIN, 32'h0001_0003); // Above terminal data
	endtask
	task automatic tAlloc();
		int n;
		axw(pia_pkg::REG_CTRL, 32'h5);
		for (n = 0; n < 300 && !xchgEn; n++)
			@(negedge clk_sys);
		chk("xchgEn", {31'h0, xchgEn}, 32'h1);
		axr(pia_pkg::REG_STAT, d, r);
		chk("stat", d, 32'h0000_0401);
		axr(pia_pkg::REG_ENDS, d, r);
		chk("ends", d, 32'h0010_0022);
	endtask
	task automatic tIn();
		putIn(4'h3, 4'h0, 32'h8000);
		chk("anaIn", {16'h0, ctlInImg[15:0]}, 32'h8000);
		putIn(4'h3, 4'h0, 32'h7FFF);
		chk("anaInRes", {16'h0, ctlInImg[15:0]}, 32'h7FF8);
		putIn(4'h1, 4'h2, 32'h1);
		chk("dirIn", {24'h0, fbDirInImg[7:0]}, 32'h4);
		chk("ctlIn", ctlInImg[31:0], 32'h7FF8);
	endtask
	task automatic tOut();
		getOut(4'h0, 4'h0, 32'hFFFF, 32'h8000);
		getOut(4'h0, 4'h1, 32'hFFFF, 32'h1234);
		getOut(4'h2, 4'h1, 32'h1, 32'h1);
		getOut(4'h2, 4'h0, 32'h1, 32'h0);
	endtask
	task automatic tWin();
		@(posedge clk_sys);
		fbStrobe <= 1'h1;
		@(posedge clk_sys);
		fbStrobe <= 1'h0;
		@(negedge clk_sys);
		chk("tx", fbTxImg[31:0], 32'hA5);
		chk("txHi", fbTxImg[63:32], 32'h0);
		chk("rx", ctlInImg[31:0], 32'hC300_7FF8);
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk_sys);
		en <= 1'h1;
		tRegs();
		tAlloc();
		tIn();
		tOut();
		tWin();
		complete_run();
	end
	// Run needs under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		complete_run();
	end
endmodule
bind pia_allocator pia_allocator_props #(.MAX_TERM(MAX_TERM), .IMG_BYTES(IMG_BYTES),
	.FB_BYTES(FB_BYTES)) props_u (.clk_sys, .rst_n, .scanReq, .scanIdx, .scanAck,
	.scanPresent, .xchgEn, .chInValid, .chOutReq, .chOutValid, .fbStrobe, .fbTxImg,
	.ctlInImg, .fbDirInImg);
